//--- common/fbw_map.vh
`ifndef FBW_MAP_VH
`define FBW_MAP_VH

// Register offsets on the 8-bit register port
`define FBW_OFS_PROG_STORE_CTRL   8'h00
`define FBW_OFS_FLASH_KEY         8'h01
`define FBW_OFS_FLASH_BUF_CTRL    8'h02
`define FBW_OFS_PROG_BANK         8'h03
`define FBW_OFS_RESET_SOURCE      8'h04
`define FBW_OFS_PART_ID           8'h05
`define FBW_OFS_WRITE_STATUS      8'h06

// Field positions
`define FBW_BIT_WRITE_EN          0
`define FBW_BIT_ERASE_EN          1
`define FBW_BIT_BLOCK_WRITE       0
`define FBW_POS_BANK_LO           0
`define FBW_POS_BANK_HI           1
`define FBW_BIT_FLASH_ERROR       6

// Reset values
`define FBW_RST_PROG_STORE_CTRL   2'h0
`define FBW_RST_FLASH_BUF_CTRL    1'h0
`define FBW_RST_PROG_BANK         2'h0
`define FBW_RST_LOCK_CFG          8'h00

// Key codes, written in this order
`define FBW_KEY_FIRST             8'ha5
`define FBW_KEY_SECOND            8'hf1

// Flash geometry
`define FBW_FLASH_AW              17
`define FBW_PAGE_SHIFT            10
`define FBW_BLOCK_BYTES           4
`define FBW_LOCK_ALL_OPEN         8'hff
`define FBW_ERASED_BYTE           8'hff

`endif

//--- dv/fbw_flash_model.sv
`timescale 1ns/1ps
module fbw_flash_model (
	input  wire       mclk,
	input  wire       fl_prog,
	input  wire       fl_erase,
	input  wire       fl_mass_erase,
	output reg        fl_busy,
	output reg  [7:0] sec_byte
);
	reg [1:0] busy_cnt;
	initial begin
		busy_cnt = 2'h0;
		fl_busy = 1'b0;
		sec_byte = 8'hff;
	end
	// Stays busy a few cycles so the stall path is really used
	always @(posedge mclk) begin
		if (fl_prog || fl_erase || fl_mass_erase)
			busy_cnt <= 2'h3;
		else if (busy_cnt != 2'h0)
			busy_cnt <= busy_cnt - 2'h1;
		fl_busy <= fl_prog || fl_erase || fl_mass_erase || busy_cnt > 2'h1;
		if (fl_mass_erase)
			sec_byte <= 8'hff;
	end
endmodule // fbw_flash_model

//--- dv/fbw_top_properties.sv
`timescale 1ns/1ps
module fbw_top_properties #(
	parameter [7:0] PART_ID = 8'h5a
) (
	input wire        mclk,
	input wire        rst_n,
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	input wire        cpu_wr,
	input wire        cpu_addr8,
	input wire [15:0] cpu_addr,
	input wire        cpu_xdata_rd,
	input wire        xram_rd,
	input wire        xram_wr,
	input wire        dbg_dev_erase,
	input wire        dbg_ready,
	input wire        dbg_done,
	input wire        dbg_refused,
	input wire        fl_prog,
	input wire [16:0] fl_prog_addr,
	input wire        fl_erase,
	input wire        fl_mass_erase,
	input wire        fl_rd,
	input wire        fl_err_rst
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence no_flash_op;
		// A debug request may legally be taken beside an external RAM write
		(!fl_prog && !fl_erase || dbg_done) && !fl_err_rst;
	endsequence
	sequence mass_answer;
		dbg_done && fl_mass_erase && !dbg_refused;
	endsequence
	a_id_read: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == PART_ID)
		else $error("part id read wrong");
	a_prog_align: assert property (fl_prog |-> fl_prog_addr[1:0] == 2'h0)
		else $error("program address not block aligned");
	a_xwr_quiet: assert property (xram_wr |=> no_flash_op)
		else $error("flash touched with write enable clear");
	a_short_form: assert property (cpu_wr && cpu_addr8 && cpu_addr[15:8] != 8'h00 |=> no_flash_op)
		else $error("short form reached high flash");
	a_xdata_ram: assert property (cpu_xdata_rd |-> xram_rd)
		else $error("data read not sent to ram");
	a_ref_quiet: assert property (dbg_refused |-> dbg_done && !fl_prog && !fl_erase && !fl_rd)
		else $error("refused debug access reached flash");
	a_ref_noreset: assert property (dbg_refused |-> !fl_err_rst && !fl_mass_erase)
		else $error("refused debug access caused reset");
	a_dev_erase: assert property (dbg_ready && dbg_dev_erase |=> mass_answer)
		else $error("device erase not carried out");
endmodule // fbw_top_properties

bind fbw_top fbw_top_properties #(.PART_ID(PART_ID)) i_props (
	.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_wr(cpu_wr), .cpu_addr8(cpu_addr8), .cpu_addr(cpu_addr), .cpu_xdata_rd(cpu_xdata_rd),
	.xram_rd(xram_rd), .xram_wr(xram_wr), .dbg_dev_erase(dbg_dev_erase), .dbg_ready(dbg_ready),
	.dbg_done(dbg_done), .dbg_refused(dbg_refused), .fl_prog(fl_prog), .fl_erase(fl_erase),
	.fl_prog_addr(fl_prog_addr), .fl_mass_erase(fl_mass_erase), .fl_rd(fl_rd),
	.fl_err_rst(fl_err_rst)
);

//--- dv/flash_block_write_security_tb.sv
`timescale 1ns/1ps
module flash_block_write_security_tb;
	localparam [7:0] PART_ID = 8'h3c; // Arbitrary value
	reg         mclk, rst_n, por_n, reg_wr, reg_rd, cpu_wr, cpu_addr8, cpu_code_rd, cpu_xdata_rd;
	reg  [7:0]  reg_addr, reg_wdata, cpu_wdata, dbg_wdata;
	reg  [15:0] cpu_addr;
	reg  [16:0] cpu_pc, dbg_addr, p_addr, e_addr, r_addr;
	reg  [3:0]  dbg_req;
	reg         rdy_q;
	reg  [31:0] got, p_data;
	wire [7:0]  reg_rdata, sec_byte;
	wire [31:0] fl_prog_data;
	wire [16:0] fl_prog_addr, fl_erase_addr, fl_rd_addr;
	wire        cpu_stall, xram_rd, xram_wr, dbg_ready, dbg_done, dbg_refused, fl_busy;
	wire        fl_prog, fl_erase, fl_mass_erase, fl_rd, fl_err_rst;
	integer     miscompares, samples_checked, n_prog, n_erase, n_mass, n_rd, n_err, n_ref, n_xr;
	integer     i, k;

	fbw_top #(.PART_ID(PART_ID)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_wr(cpu_wr),
		.cpu_addr8(cpu_addr8), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_pc(cpu_pc),
		.cpu_code_rd(cpu_code_rd), .cpu_xdata_rd(cpu_xdata_rd), .cpu_stall(cpu_stall),
		.xram_rd(xram_rd), .xram_wr(xram_wr), .dbg_rd(dbg_req[0]), .dbg_wr(dbg_req[1]),
		.dbg_erase(dbg_req[2]), .dbg_dev_erase(dbg_req[3]), .dbg_addr(dbg_addr),
		.dbg_wdata(dbg_wdata), .dbg_ready(dbg_ready), .dbg_done(dbg_done),
		.dbg_refused(dbg_refused), .sec_byte(sec_byte), .fl_busy(fl_busy), .fl_prog(fl_prog),
		.fl_prog_addr(fl_prog_addr), .fl_prog_data(fl_prog_data), .fl_erase(fl_erase),
		.fl_erase_addr(fl_erase_addr), .fl_mass_erase(fl_mass_erase), .fl_rd(fl_rd),
		.fl_rd_addr(fl_rd_addr), .fl_err_rst(fl_err_rst)
	);
	fbw_flash_model i_fl (
		.mclk(mclk), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_mass_erase(fl_mass_erase),
		.fl_busy(fl_busy), .sec_byte(sec_byte)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		rdy_q <= dbg_ready;
		n_prog <= n_prog + fl_prog;
		n_erase <= n_erase + fl_erase;
		n_mass <= n_mass + fl_mass_erase;
		n_rd <= n_rd + fl_rd;
		n_err <= n_err + fl_err_rst;
		n_ref <= n_ref + dbg_refused;
		n_xr <= n_xr + (xram_rd | xram_wr);
		if (fl_prog) begin
			p_addr <= fl_prog_addr;
			p_data <= fl_prog_data;
		end
		if (fl_erase)
			e_addr <= fl_erase_addr;
		if (fl_rd)
			r_addr <= fl_rd_addr;
	end

	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t got %h expected %h", $time, g, e);
			end
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", samples_checked, miscompares);
			if (miscompares == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	task hang;
		begin
			$display("[ERR] %0t wait timed out", $time);
			miscompares = miscompares + 1;
			report_and_stop;
		end
	endtask

	task rst;
		begin
			@(posedge mclk);
			rst_n <= 1'b0;
			repeat (5) @(posedge mclk);
			rst_n <= 1'b1;
			repeat (3) @(posedge mclk);
			#1;
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask

	task rd(input [7:0] a);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 got = {24'h0, reg_rdata};
		end
	endtask

	task key;
		begin
			wr(8'h01, 8'ha5);
			wr(8'h01, 8'hf1);
		end
	endtask

	// Kind 0 data-move write, 1 code read, 2 external data read
	task cpu(input [1:0] t, input [15:0] a, input [7:0] d, input s);
		begin
			#1 i = 0;
			while (cpu_stall !== 1'b0 && i < 40) begin
				@(posedge mclk);
				#1 i = i + 1;
			end
			if (cpu_stall !== 1'b0)
				hang;
			@(posedge mclk);
			cpu_wr <= (t == 2'd0);
			cpu_code_rd <= (t == 2'd1);
			cpu_xdata_rd <= (t == 2'd2);
			cpu_addr <= a;
			cpu_wdata <= d;
			cpu_addr8 <= s;
			@(posedge mclk);
			{cpu_wr, cpu_code_rd, cpu_xdata_rd} <= 3'h0;
			repeat (2) @(posedge mclk);
			#1;
		end
	endtask

	// Request is held until an edge that finds the port ready
	task dbg(input [3:0] r, input [16:0] a);
		begin
			i = 0;
			@(posedge mclk);
			dbg_req <= r;
			dbg_addr <= a;
			@(posedge mclk);
			#1;
			while (rdy_q !== 1'b1 && i < 40) begin
				@(posedge mclk);
				#1 i = i + 1;
			end
			if (rdy_q !== 1'b1)
				hang;
			dbg_req <= 4'h0;
			repeat (2) @(posedge mclk);
			#1;
		end
	endtask

	initial begin
		{rst_n, por_n, reg_wr, reg_rd, cpu_wr, cpu_addr8, cpu_code_rd, cpu_xdata_rd} = 8'h00;
		{reg_addr, reg_wdata, cpu_wdata, dbg_wdata, cpu_addr, dbg_addr, dbg_req} = 0;
		cpu_pc = 17'h04000;
		rdy_q = 1'b0;
		{miscompares, samples_checked} = 0;
		rst;
		por_n = 1'b1;
		{n_prog, n_erase, n_mass, n_rd, n_err, n_ref, n_xr} = 0;
		rd(8'h05);
		chk(got, PART_ID);
		rd(8'h04);
		chk(got[6], 1'b0);
		rd(8'h3f);
		chk(got, 0);
		cpu(2'd0, 16'h4000, 8'h00, 1'b0);
		cpu(2'd2, 16'h4000, 8'h00, 1'b0);
		chk(n_xr, 2);
		chk(n_prog + n_erase + n_rd, 0);
		$display("registers and ram path done");
		wr(8'h02, 8'h01);
		wr(8'h00, 8'h01);
		for (k = 0; k < 4; k = k + 1) begin
			chk(n_prog, 0);
			key;
			cpu(2'd0, 16'h4000 + k, 8'h10 + k, 1'b0);
		end
		chk(n_prog, 1);
		chk(p_addr, 17'h04000);
		chk(p_data, 32'h13121110);
		rd(8'h01);
		chk(got, 8'h01);
		key;
		cpu(2'd0, 16'h4010, 8'h00, 1'b0);
		wr(8'h02, 8'h00);
		wr(8'h02, 8'h01);
		key;
		cpu(2'd0, 16'h4013, 8'h33, 1'b0);
		chk(p_data, 32'h33ffffff);
		wr(8'h00, 8'h00);
		wr(8'h02, 8'h00);
		$display("block write done");
		wr(8'h00, 8'h01);
		key;
		cpu(2'd0, 16'h0100, 8'h00, 1'b1);
		chk(n_prog, 2);
		cpu(2'd0, 16'h0004, 8'h5a, 1'b1);
		chk(p_data, 32'hffffff5a);
		chk(p_addr, 17'h00004);
		wr(8'h01, 8'h00);
		key;
		cpu(2'd0, 16'h4020, 8'h00, 1'b0);
		chk(n_prog, 3);
		rd(8'h01);
		chk(got, 8'h08);
		rst;
		wr(8'h00, 8'h03);
		key;
		cpu(2'd0, 16'h4123, 8'h00, 1'b0);
		chk(n_erase, 1);
		chk(e_addr, 17'h04000);
		$display("short form, key and erase done");
		i_fl.sec_byte = 8'hfd;
		dbg(4'h1, 17'h00010);
		chk(n_rd, 1);
		rst;
		dbg(4'h1, 17'h00010);
		chk(n_ref, 1);
		dbg(4'h1, 17'h01400);
		chk(n_rd, 2);
		chk(r_addr, 17'h01400);
		@(posedge mclk);
		dbg_wdata <= 8'h3c;
		dbg(4'h2, 17'h01402);
		chk(p_data, 32'hff3cffff);
		chk(p_addr, 17'h01400);
		dbg(4'h4, 17'h1fc00);
		chk(n_ref, 2);
		chk(n_err, 0);
		cpu(2'd1, 16'h0010, 8'h00, 1'b0);
		chk(n_err, 1);
		rst;
		rd(8'h04);
		chk(got[6], 1'b1);
		cpu_pc = 17'h00100;
		cpu(2'd1, 16'h0010, 8'h00, 1'b0);
		chk(n_rd, 3);
		chk(r_addr, 17'h00010);
		wr(8'h03, 8'h03);
		wr(8'h00, 8'h03);
		key;
		cpu(2'd0, 16'hfc00, 8'h00, 1'b0);
		chk(n_err, 2);
		rst;
		dbg(4'h8, 17'h00000);
		chk(n_mass, 1);
		i_fl.sec_byte = 8'h80;
		rst;
		dbg(4'h1, 17'h19000);
		chk(n_ref, 3);
		dbg(4'h2, 17'h1ffff);
		chk(n_ref, 4);
		$display("security done");
		report_and_stop;
	end
endmodule // flash_block_write_security_tb

//--- verilog/fbw_top.v
`timescale 1ns/1ps
`include "fbw_map.vh"

// Overview of operation
// [RULE_01] Block mode programs four bytes in one pulse
// [RULE_02] Buffer bytes 00b-10b, commit on 11b write
// [RULE_03] No 11b write means block never programmed
// [RULE_04] Programming only clears bits; unwritten lanes 0xff
// [RULE_05] Host sends both keys before each byte
// [RULE_06] Host sets enables around block sequence
// [RULE_07] 8-bit form never modifies above 0x00ff
// [RULE_08] External data reads always go to RAM
// [RULE_09] Write needs write enable; erase needs both
// [RULE_10] Inverted lock byte counts locked pages from zero
// [RULE_11] Lock byte page locked when any page locked
// [RULE_12] Top byte on largest part; 0x80 locks all
// [RULE_13] Unlocked pages open to everyone
// [RULE_14] Protected areas: debug refused, firmware depends on origin
// [RULE_15] Firmware lock page erase always faults
// [RULE_16] Written lock byte only cleared by device erase
// [RULE_17] Reserved area refused or faulting for all
// [RULE_18] Firmware violation resets; error flag reads one
// [RULE_19] Debug violations ignored silently, no reset
// [RULE_20] New lock settings apply after next reset
// [RULE_21] Readable part identification register
// [RULE_22] Ordered keys; bad key disables until reset
// [RULE_23] Partial block dropped on disable or reset
module fbw_top #(
	parameter FLASH_BYTES    = 131072,
	parameter RESERVED_BYTES = 0,
	parameter [7:0] PART_ID  = 8'h5a
) (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        por_n,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        cpu_wr,
	input  wire        cpu_addr8,
	input  wire [15:0] cpu_addr,
	input  wire [7:0]  cpu_wdata,
	input  wire        cpu_code_rd,
	input  wire        cpu_xdata_rd,
	input  wire [16:0] cpu_pc,
	output wire        cpu_stall,
	output wire        xram_rd,
	output wire        xram_wr,
	input  wire        dbg_rd,
	input  wire        dbg_wr,
	input  wire        dbg_erase,
	input  wire        dbg_dev_erase,
	input  wire [16:0] dbg_addr,
	input  wire [7:0]  dbg_wdata,
	output wire        dbg_ready,
	output reg         dbg_done,
	output reg         dbg_refused,
	input  wire [7:0]  sec_byte,
	input  wire        fl_busy,
	output reg         fl_prog,
	output reg  [16:0] fl_prog_addr,
	output reg  [31:0] fl_prog_data,
	output reg         fl_erase,
	output reg  [16:0] fl_erase_addr,
	output reg         fl_mass_erase,
	output reg         fl_rd,
	output reg  [16:0] fl_rd_addr,
	output reg         fl_err_rst
);

	localparam AW = `FBW_FLASH_AW;
	localparam PS = `FBW_PAGE_SHIFT;
	localparam integer LOCK_ADDR_I = FLASH_BYTES - RESERVED_BYTES - 1;
	localparam integer RES_START_I = FLASH_BYTES - RESERVED_BYTES;
	localparam [AW-1:0] LOCK_ADDR  = LOCK_ADDR_I[AW-1:0];
	localparam [AW-PS-1:0] LOCK_PAGE = LOCK_ADDR[AW-1:PS];

	// Key lock: a dead lock stays dead until the next reset
	localparam [3:0] KEY_LOCKED = 4'b0001;
	localparam [3:0] KEY_FIRST  = 4'b0010;
	localparam [3:0] KEY_OPEN   = 4'b0100;
	localparam [3:0] KEY_DEAD   = 4'b1000;

	reg         write_en;
	reg         erase_en;
	reg         block_write_enable;
	reg  [1:0]  code_bank_select;
	reg  [3:0]  key_state;
	reg  [7:0]  lock_cfg;
	reg         lock_cfg_valid;
	reg  [31:0] buf_data;
	reg  [3:0]  buf_mask;
	reg  [14:0] buf_base;
	reg         err_pend;
	reg         flash_error_flag;
	reg         rst_n_d;

	// Page is locked by count, or it is the lock byte page while anything is locked
	function prot;
		input [AW-1:0] a;
		input [7:0]    lk;
		begin
			prot = ({1'b0, a[AW-1:PS]} < ~lk) // see [RULE_10]
				|| ((a[AW-1:PS] == LOCK_PAGE) && (lk != `FBW_LOCK_ALL_OPEN)); // see [RULE_11]
		end
	endfunction

	function in_reserved;
		input [AW-1:0] a;
		begin
			in_reserved = ({15'h0, a} >= RES_START_I[31:0]);
		end
	endfunction

	// Upper half of the 16-bit space is banked
	function [AW-1:0] phys;
		input [15:0] a;
		input [1:0]  bank;
		begin
			phys = a[15] ? {bank, a[14:0]} : {2'b00, a[14:0]};
		end
	endfunction

	wire [AW-1:0] cpu_pa      = phys(cpu_addr, code_bank_select);
	wire          fw_on_lock  = prot(cpu_pc, lock_cfg);
	wire          cpu_mod     = cpu_wr & write_en; // see [RULE_09]
	wire          cpu_is_er   = erase_en; // see [RULE_09]
	// Live contents: a lock byte written since reset already counts as used
	wire          lock_written = (sec_byte != `FBW_LOCK_ALL_OPEN);
	wire          cpu_lockpg  = (cpu_pa[AW-1:PS] == LOCK_PAGE);
	wire          cpu_res     = in_reserved(cpu_pa);
	wire          cpu_prot    = prot(cpu_pa, lock_cfg);
	wire          cpu_high8   = cpu_addr8 & (cpu_addr[15:8] != 8'h00);
	wire          key_open    = (key_state == KEY_OPEN);

	// Firmware access checks
	// Security is judged before the key, so a violation resets even with the key shut
	wire fw_mod_err = cpu_res // see [RULE_17]
		| (cpu_is_er & cpu_lockpg) // see [RULE_15]
		| (~cpu_is_er & (cpu_pa == LOCK_ADDR) & lock_written) // see [RULE_16]
		| (cpu_prot & ~fw_on_lock); // see [RULE_14]
	wire fw_rd_err  = cpu_res | (cpu_prot & ~fw_on_lock); // see [RULE_14]

	// Debug port checks; unlocked pages pass through untouched, except lock byte writes and lock page erases once the lock byte is written
	wire dbg_res    = in_reserved(dbg_addr);
	wire dbg_prot   = prot(dbg_addr, lock_cfg);
	wire dbg_bad_rd = dbg_res | dbg_prot; // see [RULE_13]
	wire dbg_bad_wr = dbg_res | dbg_prot | ((dbg_addr == LOCK_ADDR) & lock_written); // see [RULE_16]
	// Erasing the lock byte page would also undo a lock byte written since reset
	wire dbg_bad_er = dbg_res | dbg_prot // see [RULE_15]
		| ((dbg_addr[AW-1:PS] == LOCK_PAGE) & lock_written); // see [RULE_16]
	wire dbg_any    = dbg_rd | dbg_wr | dbg_erase | dbg_dev_erase;

	wire cpu_any    = cpu_mod | cpu_code_rd;
	wire op_issued  = fl_prog | fl_erase | fl_mass_erase;
	wire key_wr     = reg_wr & (reg_addr == `FBW_OFS_FLASH_KEY);

	// One request per edge: a key write outranks the CPU and the CPU the debug port,
	// so ready drops whenever a higher source owns the edge
	wire cpu_take   = cpu_mod & ~cpu_stall & lock_cfg_valid & ~key_wr;
	wire code_take  = cpu_code_rd & ~cpu_stall & lock_cfg_valid & ~key_wr;
	wire dbg_take   = dbg_any & dbg_ready;

	assign cpu_stall = fl_busy | op_issued;
	assign dbg_ready = ~cpu_any & ~key_wr & ~cpu_stall & lock_cfg_valid;
	assign xram_rd   = cpu_xdata_rd; // see [RULE_08]
	// With writes disabled a data-move write goes to external RAM
	assign xram_wr   = cpu_wr & ~write_en;

	// Byte lane merge: lanes not written stay erased so they are left alone
	wire [1:0]  cpu_lane  = cpu_pa[1:0];
	wire        same_blk  = (buf_base == cpu_pa[AW-1:2]);
	wire [31:0] cpu_merge;
	wire [31:0] dbg_merge;
	// Debug writes are single bytes; the block cache serves firmware only
	genvar g;
	generate
		for (g = 0; g < `FBW_BLOCK_BYTES; g = g + 1) begin : g_lane
			assign cpu_merge[g*8 +: 8] = (cpu_lane == g) ? cpu_wdata :
				(block_write_enable & same_blk & buf_mask[g]) ? buf_data[g*8 +: 8] :
				`FBW_ERASED_BYTE; // see [RULE_04]
			assign dbg_merge[g*8 +: 8] = (dbg_addr[1:0] == g) ? dbg_wdata :
				`FBW_ERASED_BYTE; // see [RULE_04]
		end
	endgenerate

	// Lock settings are read once per reset so a fresh lock byte waits for the next one
	// Until then every page counts as locked and no firmware or debug request is taken
	always @(posedge mclk) begin
		if (!rst_n) begin
			lock_cfg       <= `FBW_RST_LOCK_CFG;
			lock_cfg_valid <= 1'b0;
		end else if (!lock_cfg_valid) begin
			lock_cfg       <= sec_byte; // see [RULE_20]
			lock_cfg_valid <= 1'b1;
		end
	end

	// Software registers
	always @(posedge mclk) begin
		if (!rst_n) begin
			{erase_en, write_en} <= `FBW_RST_PROG_STORE_CTRL;
			block_write_enable <= `FBW_RST_FLASH_BUF_CTRL;
			code_bank_select   <= `FBW_RST_PROG_BANK;
		end else if (reg_wr) begin
			case (reg_addr)
				`FBW_OFS_PROG_STORE_CTRL: begin
					write_en <= reg_wdata[`FBW_BIT_WRITE_EN];
					erase_en <= reg_wdata[`FBW_BIT_ERASE_EN];
				end
				`FBW_OFS_FLASH_BUF_CTRL: begin
					block_write_enable <= reg_wdata[`FBW_BIT_BLOCK_WRITE];
				end
				`FBW_OFS_PROG_BANK: begin
					code_bank_select <= reg_wdata[`FBW_POS_BANK_HI:`FBW_POS_BANK_LO];
				end
				default: begin
				end
			endcase
		end
	end

	// Read port, data in the cycle after the strobe only
	always @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`FBW_OFS_PROG_STORE_CTRL: reg_rdata <= {6'h00, erase_en, write_en};
				`FBW_OFS_FLASH_KEY:       reg_rdata <= {4'h0, key_state};
				`FBW_OFS_FLASH_BUF_CTRL:  reg_rdata <= {7'h00, block_write_enable};
				`FBW_OFS_PROG_BANK:       reg_rdata <= {6'h00, code_bank_select};
				`FBW_OFS_RESET_SOURCE:    reg_rdata <= {1'b0, flash_error_flag, 6'h00}; // see [RULE_18]
				`FBW_OFS_PART_ID:         reg_rdata <= PART_ID; // see [RULE_21]
				`FBW_OFS_WRITE_STATUS:    reg_rdata <= {lock_written, fl_busy, 2'b00, buf_mask};
				default:                  reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Main sequencer: key lock, firmware and debug requests, block cache
	always @(posedge mclk) begin
		if (!rst_n) begin
			key_state     <= KEY_LOCKED;
			buf_data      <= 32'h0000_0000;
			buf_mask      <= 4'h0; // see [RULE_23]
			buf_base      <= 15'h0000;
			fl_prog       <= 1'b0;
			fl_prog_addr  <= 17'h00000;
			fl_prog_data  <= 32'hffff_ffff;
			fl_erase      <= 1'b0;
			fl_erase_addr <= 17'h00000;
			fl_mass_erase <= 1'b0;
			fl_rd         <= 1'b0;
			fl_rd_addr    <= 17'h00000;
			fl_err_rst    <= 1'b0;
			dbg_done      <= 1'b0;
			dbg_refused   <= 1'b0;
		end else begin
			fl_prog       <= 1'b0;
			fl_erase      <= 1'b0;
			fl_mass_erase <= 1'b0;
			fl_rd         <= 1'b0;
			fl_err_rst    <= 1'b0;
			dbg_done      <= 1'b0;
			dbg_refused   <= 1'b0;
			// Leaving block mode drops a partial block
			if (!block_write_enable) begin
				buf_mask <= 4'h0; // see [RULE_23]
			end
			if (key_wr) begin
				case (key_state)
					KEY_LOCKED: key_state <= (reg_wdata == `FBW_KEY_FIRST) ?
						KEY_FIRST : KEY_DEAD; // see [RULE_22]
					KEY_FIRST:  key_state <= (reg_wdata == `FBW_KEY_SECOND) ?
						KEY_OPEN : KEY_DEAD; // see [RULE_22]
					KEY_OPEN:   key_state <= KEY_DEAD;
					KEY_DEAD:   key_state <= KEY_DEAD;
					default:    key_state <= KEY_DEAD;
				endcase
			end else if (cpu_take) begin
				if (cpu_high8) begin
					// Short-form pointer cannot reach past the first 256 bytes
					key_state <= key_state; // see [RULE_07]
				end else if (fw_mod_err) begin
					fl_err_rst <= 1'b1; // see [RULE_18]
				end else if (!key_open) begin
					key_state <= KEY_DEAD; // see [RULE_22]
				end else begin
					key_state <= KEY_LOCKED; // see [RULE_22]
					if (cpu_is_er) begin
						fl_erase      <= 1'b1;
						fl_erase_addr <= {cpu_pa[AW-1:PS], 10'h000};
						buf_mask      <= 4'h0;
					end else if (block_write_enable && (cpu_lane != 2'b11)) begin
						// Hold the byte; a new block throws away an old partial one
						buf_base <= cpu_pa[AW-1:2];
						buf_data <= cpu_merge; // see [RULE_02]
						buf_mask <= (same_blk ? buf_mask : 4'h0)
							| (4'h1 << cpu_lane); // see [RULE_03]
					end else begin
						fl_prog      <= 1'b1; // see [RULE_01]
						fl_prog_addr <= {cpu_pa[AW-1:2], 2'b00};
						fl_prog_data <= cpu_merge; // see [RULE_02]
						buf_mask     <= 4'h0;
					end
				end
			end else if (code_take) begin
				if (fw_rd_err) begin
					fl_err_rst <= 1'b1; // see [RULE_14]
				end else begin
					fl_rd      <= 1'b1;
					fl_rd_addr <= cpu_pa;
				end
			end else if (dbg_take) begin
				dbg_done <= 1'b1;
				if (dbg_dev_erase) begin
					fl_mass_erase <= 1'b1; // see [RULE_16]
					buf_mask      <= 4'h0;
				end else if (dbg_erase) begin
					if (dbg_bad_er) begin
						dbg_refused <= 1'b1; // see [RULE_19]
					end else begin
						fl_erase      <= 1'b1; // see [RULE_13]
						fl_erase_addr <= {dbg_addr[AW-1:PS], 10'h000};
					end
				end else if (dbg_wr) begin
					if (dbg_bad_wr) begin
						dbg_refused <= 1'b1; // see [RULE_19]
					end else begin
						fl_prog      <= 1'b1;
						fl_prog_addr <= {dbg_addr[AW-1:2], 2'b00};
						fl_prog_data <= dbg_merge;
					end
				end else begin
					if (dbg_bad_rd) begin
						dbg_refused <= 1'b1; // see [RULE_14]
					end else begin
						fl_rd      <= 1'b1;
						fl_rd_addr <= dbg_addr;
					end
				end
			end
		end
	end

	// Error cause must outlive the reset it triggers, so each reset reloads the flag from it and power-on clears both
	always @(posedge mclk) begin
		if (!por_n) begin
			err_pend         <= 1'b0;
			flash_error_flag <= 1'b0;
			rst_n_d          <= 1'b0;
		end else begin
			rst_n_d <= rst_n;
			if (!rst_n) begin
				flash_error_flag <= err_pend; // see [RULE_18]
			end
			// A new error outranks the clear left from the previous reset
			if (fl_err_rst) begin
				err_pend <= 1'b1;
			end else if (rst_n & ~rst_n_d) begin
				err_pend <= 1'b0;
			end
		end
	end

endmodule // fbw_top
